// ### design/omseq_sequencer.sv
// Operating mode state machine with reset deglitch and mode timers
`timescale 1ns/1ns

module omseq_sequencer #(
  parameter int unsigned NVM_CYC = omseq_pkg::NVM_DEF_CYC,
  parameter int unsigned POLL_CYC = omseq_pkg::POLL_DEF_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic por_ok_i,
  input wire logic rst_pin_i,
  input wire logic nvm_ready_i,
  input wire logic trim_invalid_i,
  input wire logic calib_invalid_i,
  input wire logic diag_ok_i,
  input wire logic overtemp_i,
  input wire logic ot_mask_i,
  input wire logic internal_supply_fault_i,
  input wire logic wake_src_change_i,
  input wire logic addr_sel_i,
  input wire logic wcfg_wr_i,
  input wire omseq_pkg::omseq_wcfg_t wcfg_i,
  input wire logic status_rd_i,
  output omseq_pkg::omseq_state_t state_o,
  output omseq_pkg::omseq_flags_t flags_o,
  output logic wake_o,
  output logic chip_addr_o,
  output logic spi_ready_o,
  output logic vref_en_o,
  output logic [1:0] blanking_timeout_o,
  output logic [1:0] polling_timeout_o
);

  localparam int TW = omseq_pkg::TMR_W;
  localparam int DW = omseq_pkg::DEGL_W;
  localparam logic [TW-1:0] BLANK_BASE = TW'(omseq_pkg::BLANK_DEF_CYC);
  localparam logic [TW-1:0] POLL_BASE = TW'(POLL_CYC);
  localparam logic [TW-1:0] NVM_LIM = TW'(NVM_CYC);
  localparam logic [DW-1:0] DEGL_NORM = DW'(omseq_pkg::DEGL_NORM_CYC);
  localparam logic [DW-1:0] DEGL_SLEEP = DW'(omseq_pkg::DEGL_SLEEP_CYC);
  localparam logic [TW-1:0] TMR_MAX = {TW{1'b1}};

  // Field code to cycle count, zero code keeps the default
  function automatic logic [TW-1:0] tsel_cycles(
    input logic [1:0] sel,
    input logic [TW-1:0] base
  );
    logic [TW-1:0] r;
    r = base;
    unique case (sel)
      omseq_pkg::TSEL_DEF: r = base;
      omseq_pkg::TSEL_HALF: r = base >> 1;
      omseq_pkg::TSEL_DOUBLE: r = base << 1;
      omseq_pkg::TSEL_QUAD: r = base << 2;
    endcase
    return r;
  endfunction

  omseq_pkg::omseq_state_t state;
  omseq_pkg::omseq_state_t next_state;
  omseq_pkg::omseq_flags_t flags;
  logic por_q;
  logic rst_filt;
  logic [DW-1:0] degl_cnt;
  logic [DW-1:0] degl_lim;
  logic degl_flip;
  logic rst_rise;
  logic rst_fall;
  logic [TW-1:0] tmr;
  logic [TW-1:0] tmr_lim;
  logic tmr_done;
  logic [TW-1:0] pers;
  logic pers_done;
  logic diag_q;
  logic [1:0] blank_sel;
  logic [1:0] poll_sel;
  logic [1:0] arm_cnt;
  logic sleep_armed;
  logic fault_now;
  logic dl_clean;
  logic wake_entry;
  logic [TW-1:0] blank_cyc;
  logic [TW-1:0] poll_cyc;

  assign blank_cyc = tsel_cycles(blank_sel, BLANK_BASE);
  assign poll_cyc = tsel_cycles(poll_sel, POLL_BASE);
  assign fault_now = (overtemp_i && !ot_mask_i)
                     || internal_supply_fault_i;
  assign dl_clean = diag_ok_i && !trim_invalid_i && !calib_invalid_i;
  assign sleep_armed = (arm_cnt == omseq_pkg::ACT_REPEAT);
  assign wake_entry = (next_state == omseq_pkg::OMSEQ_WAKE)
                      && (state != omseq_pkg::OMSEQ_WAKE);

  // Longer filter in low power modes, where the pin may be noisy
  assign degl_lim = (state == omseq_pkg::OMSEQ_SLEEP
                     || state == omseq_pkg::OMSEQ_POLLING)
                    ? DEGL_SLEEP : DEGL_NORM;
  // At or above the limit: a mode change may shorten the filter mid-count
  assign degl_flip = (rst_pin_i != rst_filt)
                     && (degl_cnt >= degl_lim - DW'(1));
  assign rst_rise = degl_flip && rst_pin_i;
  assign rst_fall = degl_flip && !rst_pin_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      degl_cnt <= '0;
      rst_filt <= 1'b0;
    end else if (rst_pin_i == rst_filt) begin
      degl_cnt <= '0;
    end else if (degl_flip) begin
      degl_cnt <= '0;
      rst_filt <= rst_pin_i;
    end else begin
      degl_cnt <= degl_cnt + DW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_q <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      por_q <= por_ok_i;
      diag_q <= diag_ok_i;
    end
  end

  always_comb begin
    unique case (state)
      omseq_pkg::OMSEQ_DOWNLOAD: tmr_lim = NVM_LIM;
      omseq_pkg::OMSEQ_INIT: tmr_lim = blank_cyc;
      omseq_pkg::OMSEQ_POLLING: tmr_lim = blank_cyc;
      omseq_pkg::OMSEQ_SLEEP: tmr_lim = poll_cyc;
      default: tmr_lim = TMR_MAX;
    endcase
  end
  assign tmr_done = (tmr >= tmr_lim - TW'(1));
  assign pers_done = (pers >= blank_cyc + poll_cyc - TW'(1));

  always_comb begin
    next_state = state;
    if (!por_ok_i) begin
      next_state = omseq_pkg::OMSEQ_OFF;
    end else begin
      unique case (state)
        omseq_pkg::OMSEQ_OFF: begin
          if (!por_q) next_state = omseq_pkg::OMSEQ_DOWNLOAD;
        end
        omseq_pkg::OMSEQ_DOWNLOAD: begin
          // Early wake needs a good supply; the load timeout wakes regardless
          if (nvm_ready_i && dl_clean && !internal_supply_fault_i) begin
            next_state = omseq_pkg::OMSEQ_WAKE;
          end else if (tmr_done) begin
            next_state = omseq_pkg::OMSEQ_WAKE;
          end
        end
        omseq_pkg::OMSEQ_WAKE: begin
          if (rst_rise) next_state = omseq_pkg::OMSEQ_INIT;
        end
        omseq_pkg::OMSEQ_INIT: begin
          if (rst_fall) begin
            next_state = omseq_pkg::OMSEQ_RST_ACTIVE;
          end else if (tmr_done && diag_ok_i == diag_q) begin
            next_state = diag_ok_i ? omseq_pkg::OMSEQ_NORMAL
                                   : omseq_pkg::OMSEQ_FAULT;
          end
        end
        omseq_pkg::OMSEQ_NORMAL: begin
          if (rst_fall) begin
            next_state = sleep_armed ? omseq_pkg::OMSEQ_SLEEP
                                     : omseq_pkg::OMSEQ_RST_ACTIVE;
          end else if (fault_now) begin
            next_state = omseq_pkg::OMSEQ_FAULT;
          end
        end
        omseq_pkg::OMSEQ_FAULT: begin
          if (rst_fall) begin
            next_state = omseq_pkg::OMSEQ_RST_ACTIVE;
          end else if (!fault_now && diag_ok_i) begin
            next_state = omseq_pkg::OMSEQ_NORMAL;
          end
        end
        omseq_pkg::OMSEQ_SLEEP: begin
          if (rst_rise) begin
            next_state = omseq_pkg::OMSEQ_INIT;
          end else if (tmr_done) begin
            next_state = omseq_pkg::OMSEQ_POLLING;
          end
        end
        omseq_pkg::OMSEQ_POLLING: begin
          if (rst_rise) begin
            next_state = omseq_pkg::OMSEQ_INIT;
          end else if (pers_done) begin
            next_state = omseq_pkg::OMSEQ_WAKE;
          end else if (tmr_done && !wake_src_change_i) begin
            next_state = omseq_pkg::OMSEQ_SLEEP;
          end
        end
        omseq_pkg::OMSEQ_RST_ACTIVE: begin
          if (rst_rise) next_state = omseq_pkg::OMSEQ_INIT;
        end
        default: next_state = omseq_pkg::OMSEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= omseq_pkg::OMSEQ_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Init timer restarts when diagnostics change, so the decision
  // is taken only on a level that held for the whole blanking time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr <= '0;
    end else if (next_state != state) begin
      tmr <= '0;
    end else if (state == omseq_pkg::OMSEQ_INIT && diag_ok_i != diag_q) begin
      tmr <= '0;
    end else if (!tmr_done) begin
      tmr <= tmr + TW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pers <= '0;
    end else if (state == omseq_pkg::OMSEQ_POLLING && wake_src_change_i) begin
      if (!pers_done) pers <= pers + TW'(1);
    end else begin
      pers <= '0;
    end
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags <= '0;
    end else begin
      if (wake_entry) begin
        flags.wakeup_flag <= 1'b1;
      end else if (status_rd_i) begin
        flags.wakeup_flag <= 1'b0;
      end
      if (state == omseq_pkg::OMSEQ_OFF) begin
        flags.trimming_fault_flag <= 1'b0;
        flags.calibration_fault_flag <= 1'b0;
      end else if (state == omseq_pkg::OMSEQ_DOWNLOAD && wake_entry) begin
        flags.trimming_fault_flag <= trim_invalid_i;
        flags.calibration_fault_flag <= calib_invalid_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_addr_o <= 1'b0;
    end else if (next_state == omseq_pkg::OMSEQ_INIT && rst_rise) begin
      chip_addr_o <= addr_sel_i;
    end
  end

  // SPI stays up through fault; any other mode waits for normal again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_ready_o <= 1'b0;
    end else if (state == omseq_pkg::OMSEQ_NORMAL) begin
      spi_ready_o <= 1'b1;
    end else if (state != omseq_pkg::OMSEQ_FAULT) begin
      spi_ready_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vref_en_o <= 1'b0;
    end else begin
      vref_en_o <= (next_state == omseq_pkg::OMSEQ_INIT)
                   || (next_state == omseq_pkg::OMSEQ_NORMAL)
                   || (next_state == omseq_pkg::OMSEQ_FAULT);
    end
  end

  // Configuration survives sleep but not off or reset active
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blank_sel <= omseq_pkg::TSEL_DEF;
      poll_sel <= omseq_pkg::TSEL_DEF;
    end else if (state == omseq_pkg::OMSEQ_OFF
                 || state == omseq_pkg::OMSEQ_RST_ACTIVE) begin
      blank_sel <= omseq_pkg::TSEL_DEF;
      poll_sel <= omseq_pkg::TSEL_DEF;
    end else if (wcfg_wr_i && spi_ready_o) begin
      blank_sel <= wcfg_i.blanking_timeout;
      poll_sel <= wcfg_i.polling_timeout;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arm_cnt <= omseq_pkg::ARM_RESET;
    end else if (!spi_ready_o || next_state == omseq_pkg::OMSEQ_SLEEP) begin
      arm_cnt <= omseq_pkg::ARM_RESET;
    end else if (wcfg_wr_i) begin
      if (wcfg_i.code != omseq_pkg::ACT_CODE) begin
        arm_cnt <= omseq_pkg::ARM_RESET;
      end else if (!sleep_armed) begin
        arm_cnt <= arm_cnt + 2'h1;
      end
    end
  end

  assign state_o = state;
  assign flags_o = flags;
  assign wake_o = flags.wakeup_flag;
  assign blanking_timeout_o = blank_sel;
  assign polling_timeout_o = poll_sel;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence seq_init_ends;
    state == omseq_pkg::OMSEQ_INIT && tmr_done && !rst_fall && por_ok_i
    && diag_ok_i == diag_q;
  endsequence

  sequence seq_normal_then_fault;
    state == omseq_pkg::OMSEQ_NORMAL ##1 state == omseq_pkg::OMSEQ_FAULT;
  endsequence

  AST_POR_START: assert property (
    state == omseq_pkg::OMSEQ_OFF && por_ok_i && !por_q
    |=> state == omseq_pkg::OMSEQ_DOWNLOAD)
    else $error("power-on edge did not start download");

  AST_TRIM_FLAG: assert property (
    state == omseq_pkg::OMSEQ_DOWNLOAD && por_ok_i && tmr_done
    && trim_invalid_i |=> state == omseq_pkg::OMSEQ_WAKE
    && flags_o.trimming_fault_flag)
    else $error("bad trim did not wake with flag");

  AST_WAKE_PIN: assert property (
    $rose(state == omseq_pkg::OMSEQ_WAKE) |-> wake_o
    && flags_o.wakeup_flag)
    else $error("wake entry without pin and flag");

  AST_FLAG_CLEAR: assert property (
    wake_o && status_rd_i && !wake_entry |=> !wake_o
    ##1 (wake_o == $past(wake_entry)))
    else $error("status read did not clear wake");

  AST_ADDR_LATCH: assert property (
    state == omseq_pkg::OMSEQ_WAKE && rst_rise && por_ok_i
    |=> state == omseq_pkg::OMSEQ_INIT && chip_addr_o == $past(addr_sel_i))
    else $error("address select not latched on init entry");

  AST_INIT_NORMAL: assert property (
    seq_init_ends ##0 diag_ok_i |=> state == omseq_pkg::OMSEQ_NORMAL
    ##1 spi_ready_o || state != omseq_pkg::OMSEQ_NORMAL)
    else $error("healthy init did not reach normal");

  AST_INIT_FAULT: assert property (
    seq_init_ends ##0 !diag_ok_i |=> state == omseq_pkg::OMSEQ_FAULT)
    else $error("failing init did not reach fault");

  AST_NO_EARLY_SPI: assert property (
    $rose(spi_ready_o) |-> $past(state) == omseq_pkg::OMSEQ_NORMAL)
    else $error("spi ready before normal");

  AST_FAULT_KEEPS: assert property (
    seq_normal_then_fault |-> spi_ready_o ##1 vref_en_o
    || state != omseq_pkg::OMSEQ_FAULT)
    else $error("fault dropped spi or reference");

  AST_NORMAL_FAULT: assert property (
    state == omseq_pkg::OMSEQ_NORMAL && por_ok_i && !rst_fall
    && internal_supply_fault_i |=> state == omseq_pkg::OMSEQ_FAULT)
    else $error("supply fault did not enter fault");

  AST_SLEEP_POLL: assert property (
    state == omseq_pkg::OMSEQ_SLEEP && tmr_done && !rst_rise && por_ok_i
    |=> state == omseq_pkg::OMSEQ_POLLING)
    else $error("polling timeout did not start polling");

  AST_RST_ACTIVE: assert property (
    (state == omseq_pkg::OMSEQ_FAULT || state == omseq_pkg::OMSEQ_INIT)
    && rst_fall && por_ok_i
    |=> state == omseq_pkg::OMSEQ_RST_ACTIVE ##1 blanking_timeout_o == 2'h0
    && polling_timeout_o == 2'h0 && !spi_ready_o)
    else $error("reset low did not discard configuration");

  AST_DEGLITCH: assert property (
    state == omseq_pkg::OMSEQ_NORMAL && rst_filt && $fell(rst_pin_i)
    ##1 !rst_pin_i [*8] |-> rst_filt)
    else $error("reset pin passed filter too early");

  AST_POR_OFF: assert property (
    !por_ok_i |=> state == omseq_pkg::OMSEQ_OFF)
    else $error("loss of supply did not force off");

endmodule

// ### inc/omseq_pkg.sv
// Constants and types of the operating mode sequencer
package omseq_pkg;

  // Clock and time figures, times in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_DEF_NS = 160_000;
  localparam int POLL_DEF_NS = 16_000_000;
  localparam int MEMORY_LOAD_TIMEOUT_NS = 3_125_000;
  localparam int DEGL_NORM_NS = 1_000;
  localparam int DEGL_SLEEP_NS = 16_000;

  // Least times round up to whole cycles
  localparam int BLANK_DEF_CYC =
    (BLANK_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_DEF_CYC =
    (POLL_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_DEF_CYC =
    (MEMORY_LOAD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGL_NORM_CYC =
    (DEGL_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGL_SLEEP_CYC =
    (DEGL_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths
  localparam int TMR_W = 24;
  localparam int DEGL_W = 9;

  // Timeout field codes: all zero selects the default duration
  localparam logic [1:0] TSEL_DEF = 2'h0;
  localparam logic [1:0] TSEL_HALF = 2'h1;
  localparam logic [1:0] TSEL_DOUBLE = 2'h2;
  localparam logic [1:0] TSEL_QUAD = 2'h3;

  // Sleep activation: code value is arbitrary
  localparam logic [7:0] ACT_CODE = 8'h5A;
  localparam logic [1:0] ACT_REPEAT = 2'h3;
  localparam logic [1:0] ARM_RESET = 2'h0;

  typedef enum logic [3:0] {
    OMSEQ_OFF = 4'h0,
    OMSEQ_DOWNLOAD = 4'h1,
    OMSEQ_WAKE = 4'h2,
    OMSEQ_INIT = 4'h3,
    OMSEQ_NORMAL = 4'h4,
    OMSEQ_FAULT = 4'h5,
    OMSEQ_SLEEP = 4'h6,
    OMSEQ_POLLING = 4'h7,
    OMSEQ_RST_ACTIVE = 4'h8
  } omseq_state_t;

  // One write to wake_config_reg
  typedef struct packed {
    logic [7:0] code;
    logic [1:0] polling_timeout;
    logic [1:0] blanking_timeout;
  } omseq_wcfg_t;

  // Flags of general_status_reg kept by this block
  typedef struct packed {
    logic wakeup_flag;
    logic calibration_fault_flag;
    logic trimming_fault_flag;
  } omseq_flags_t;

endpackage

// ### tb/omseq_host_model.sv
// Host and supply manager model driving the external reset pin
`timescale 1ns/1ns
module omseq_host_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wake_i,
  input wire logic auto_i,
  input wire logic release_i,
  input wire logic pull_low_i,
  output logic rst_pin_o
);
  logic wake_q;

  // Supply wakes on the wake pin, then lets reset go once it is up
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_q <= 1'b0;
      rst_pin_o <= 1'b0;
    end else begin
      wake_q <= wake_i;
      if (pull_low_i) begin
        rst_pin_o <= 1'b0;
      end else if (release_i || (auto_i && wake_i && !wake_q)) begin
        rst_pin_o <= 1'b1;
      end
    end
  end
endmodule

// ### tb/omseq_sequencer_bench.sv
// Self-checking bench of the operating mode sequencer
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module omseq_sequencer_bench;
  localparam int NVM = 50;
  localparam int POLL = 200;
  localparam int BLK = omseq_pkg::BLANK_DEF_CYC;
  localparam int DGN = omseq_pkg::DEGL_NORM_CYC;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic por_ok = 1'b1;
  logic nvm_ready = 1'b1;
  logic trim = 1'b1;
  logic calib = 1'b0;
  logic diag_ok = 1'b1;
  logic overtemp = 1'b0;
  logic ot_mask = 1'b0;
  logic isf = 1'b0;
  logic wake_src = 1'b0;
  logic addr_sel = 1'b0;
  logic wcfg_wr = 1'b0;
  omseq_pkg::omseq_wcfg_t wcfg = '0;
  logic status_rd = 1'b0;
  logic auto_rel = 1'b0;
  logic rel = 1'b0;
  logic pull = 1'b0;
  logic rst_pin;
  omseq_pkg::omseq_state_t state;
  omseq_pkg::omseq_flags_t flags;
  logic wake;
  logic chip_addr;
  logic spi_ready;
  logic vref_en;
  logic [1:0] bto;
  logic [1:0] pto;

  omseq_sequencer #(.NVM_CYC(NVM), .POLL_CYC(POLL)) dut (
    .clk_i(clk), .nrst_i(nrst), .por_ok_i(por_ok), .rst_pin_i(rst_pin),
    .nvm_ready_i(nvm_ready), .trim_invalid_i(trim),
    .calib_invalid_i(calib), .diag_ok_i(diag_ok), .overtemp_i(overtemp),
    .ot_mask_i(ot_mask), .internal_supply_fault_i(isf),
    .wake_src_change_i(wake_src), .addr_sel_i(addr_sel),
    .wcfg_wr_i(wcfg_wr), .wcfg_i(wcfg), .status_rd_i(status_rd),
    .state_o(state), .flags_o(flags), .wake_o(wake),
    .chip_addr_o(chip_addr), .spi_ready_o(spi_ready), .vref_en_o(vref_en),
    .blanking_timeout_o(bto), .polling_timeout_o(pto)
  );

  omseq_host_model host (
    .clk_i(clk), .nrst_i(nrst), .wake_i(wake), .auto_i(auto_rel),
    .release_i(rel), .pull_low_i(pull), .rst_pin_o(rst_pin)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 10500 cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Not before lo-3 cycles, then within a small window
  task automatic go(input omseq_pkg::omseq_state_t s, input int lo);
    int n;
    n = 0;
    tick(lo - 3);
    `CHK("early state", 1'b0, state === s)
    while (state !== s && n < 8) begin
      tick(1);
      n++;
    end
    `CHK("state", s, state)
  endtask

  task automatic wr_cfg(input logic [7:0] c, input logic [1:0] t);
    wcfg = {c, t, t};
    wcfg_wr = 1'b1;
    tick(1);
    wcfg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd_status();
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    tick(1);
  endtask

  task automatic hit(input logic low);
    pull = low;
    rel = !low;
    tick(1);
    pull = 1'b0;
    rel = 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #5;
    nrst = 1'b1;
    `CHK("off", omseq_pkg::OMSEQ_OFF, state)
    go(omseq_pkg::OMSEQ_DOWNLOAD, 3);
    go(omseq_pkg::OMSEQ_WAKE, NVM);
    `CHK("flags", 3'b101, flags)
    `CHK("wake pin", 1'b1, wake)
    `CHK("spi ready", 1'b0, spi_ready)
    wr_cfg(8'h00, omseq_pkg::TSEL_QUAD);
    `CHK("blank code", 2'h0, bto)
    rd_status();
    `CHK("wake pin", 1'b0, wake)
    `CHK("wake flag", 1'b0, flags.wakeup_flag)
    addr_sel = 1'b1;
    hit(1'b0);
    go(omseq_pkg::OMSEQ_INIT, DGN);
    `CHK("chip addr", 1'b1, chip_addr)
    addr_sel = 1'b0;
    go(omseq_pkg::OMSEQ_NORMAL, BLK);
    tick(1);
    `CHK("spi ready", 1'b1, spi_ready)
    ot_mask = 1'b1;
    overtemp = 1'b1;
    tick(6);
    `CHK("masked", omseq_pkg::OMSEQ_NORMAL, state)
    ot_mask = 1'b0;
    go(omseq_pkg::OMSEQ_FAULT, 3);
    `CHK("spi ready", 1'b1, spi_ready)
    `CHK("vref", 1'b1, vref_en)
    overtemp = 1'b0;
    go(omseq_pkg::OMSEQ_NORMAL, 3);
    isf = 1'b1;
    go(omseq_pkg::OMSEQ_FAULT, 3);
    isf = 1'b0;
    go(omseq_pkg::OMSEQ_NORMAL, 3);
    repeat (3) wr_cfg(omseq_pkg::ACT_CODE, omseq_pkg::TSEL_HALF);
    `CHK("blank code", 2'h1, bto)
    `CHK("poll code", 2'h1, pto)
    hit(1'b1);
    go(omseq_pkg::OMSEQ_SLEEP, DGN);
    `CHK("kept code", 2'h1, bto)
    `CHK("vref", 1'b0, vref_en)
    go(omseq_pkg::OMSEQ_POLLING, POLL / 2);
    go(omseq_pkg::OMSEQ_SLEEP, BLK / 2);
    go(omseq_pkg::OMSEQ_POLLING, POLL / 2);
    // Short high pulse under the sleep filter must be ignored
    hit(1'b0);
    tick(100);
    hit(1'b1);
    tick(300);
    `CHK("glitch", omseq_pkg::OMSEQ_POLLING, state)
    wake_src = 1'b1;
    auto_rel = 1'b1;
    go(omseq_pkg::OMSEQ_WAKE, BLK / 2 + POLL / 2);
    go(omseq_pkg::OMSEQ_INIT, DGN);
    wake_src = 1'b0;
    auto_rel = 1'b0;
    `CHK("chip addr", 1'b0, chip_addr)
    hit(1'b1);
    go(omseq_pkg::OMSEQ_RST_ACTIVE, DGN);
    diag_ok = 1'b0;
    hit(1'b0);
    go(omseq_pkg::OMSEQ_INIT, DGN);
    `CHK("blank code", 2'h0, bto)
    `CHK("poll code", 2'h0, pto)
    go(omseq_pkg::OMSEQ_FAULT, BLK);
    `CHK("spi ready", 1'b0, spi_ready)
    por_ok = 1'b0;
    go(omseq_pkg::OMSEQ_OFF, 3);
    diag_ok = 1'b1;
    trim = 1'b0;
    por_ok = 1'b1;
    go(omseq_pkg::OMSEQ_WAKE, 3);
    `CHK("flags", 3'b100, flags)
    calib = 1'b1;
    por_ok = 1'b0;
    go(omseq_pkg::OMSEQ_OFF, 3);
    por_ok = 1'b1;
    go(omseq_pkg::OMSEQ_DOWNLOAD, 3);
    go(omseq_pkg::OMSEQ_WAKE, NVM);
    `CHK("flags", 3'b110, flags)
    report_and_stop();
  end
endmodule
